// ===== design/pfsdh_top.sv
// Purpose: per-pin function select for port d6/d7, e, f, g, h, j pins
// Assumes: peripherals present one drive value and enable per pin and code
// Notes:   pin drive and enable are registered, so they follow a select write by one cycle
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - code zero leaves pin undriven, high-impedance
// - d6 codes 01,08,25 route on all variants
// - d6 codes 14,15 only on larger variants
// - d6 code 26 only on largest variant
// - d7 codes per variant as listed
// - e3 code 11 always, 26 largest only
// - e4/e5 ethernet codes, 26 largest only
// - e6/e7 card detect and protect codes
// - port f fields pins 0,1,2,5 only
// - port g registers absent on smallest variant
// - h0..h6 code 27 largest variant only
// - h6 code 2a routes clock output
// - j0/j1 code 11 larger, 27 largest
// - j3 code 18 always, 27 largest
// - j5 codes 11,21 always, 27 largest
module pfsdh_top
    import pfsdh_pkg::*;
#(
    parameter logic [1:0] variant = PFSDH_VAR_LARGE
) (
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst_b,
    input  wire pfsdh_axi_req_type                    axi_req,
    output var  pfsdh_axi_resp_type                   axi_resp,
    input  wire logic [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0] periph_out,
    input  wire logic [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0] periph_oe,
    input  wire logic [PFSDH_NPIN-1:0]                pin_in,
    output logic      [PFSDH_NPIN-1:0]                pin_out,
    output logic      [PFSDH_NPIN-1:0]                pin_oe,
    output logic      [PFSDH_NPIN-1:0]                pin_routed,
    output logic      [PFSDH_NPIN-1:0][PFSDH_SELW-1:0] pin_sel_code,
    output logic      [PFSDH_NPIN-1:0]                periph_in
);

    typedef struct packed {
        pfsdh_wr_state_type                    wr_state;
        pfsdh_rd_state_type                    rd_state;
        logic                                  aw_held;
        logic [5:0]                            aw_idx;
        logic                                  aw_hi_ok;
        logic                                  w_held;
        logic [5:0]                            w_sel;
        logic                                  w_lane0;
        pfsdh_axi_resp_type                    resp;
        logic [PFSDH_NPIN-1:0][PFSDH_SELW-1:0] sel;
        logic [PFSDH_NPIN-1:0]                 routed;
        logic [PFSDH_NPIN-1:0]                 drive;
        logic [PFSDH_NPIN-1:0]                 enable;
        logic [PFSDH_NPIN-1:0]                 in_q;
    } pfsdh_state_type;

    pfsdh_state_type st;
    pfsdh_state_type next_st;

    // field exists at this index for the configured variant
    function automatic logic field_present(input logic [5:0] idx);
        field_present = (idx < 6'(PFSDH_NPIN));
        if (idx >= 6'(PFSDH_IDX_G0) && idx <= 6'(PFSDH_IDX_G7) && variant == PFSDH_VAR_SMALL) begin
            field_present = 1'b0;
        end
    endfunction

    // code decoded on this pin for the configured variant
    function automatic logic code_legal(input int pin, input logic [5:0] code);
        pfsdh_mask_type m;
        m = PFSDH_BASE[pin];
        if (variant != PFSDH_VAR_SMALL) begin
            m = m | PFSDH_MID[pin];
        end
        if (variant == PFSDH_VAR_LARGE) begin
            m = m | PFSDH_TOP[pin];
        end
        code_legal = (code != PFSDH_SEL_HIZ) && m[code];
    endfunction

    always_comb begin
        logic [5:0] ridx;
        logic       hit;
        next_st = st;
        ridx = axi_req.araddr[7:2];
        hit = 1'b0;

        // write address and data, accepted in either order
        if (st.resp.awready && axi_req.awvalid) begin
            next_st.aw_held  = 1'b1;
            next_st.aw_idx   = axi_req.awaddr[7:2];
            next_st.aw_hi_ok = (axi_req.awaddr[31:8] == PFSDH_ADDR_HI_ZERO);
        end
        if (st.resp.wready && axi_req.wvalid) begin
            next_st.w_held  = 1'b1;
            next_st.w_sel   = axi_req.wdata[5:0];
            next_st.w_lane0 = axi_req.wstrb[0];
        end

        case (st.wr_state)
            PFSDH_WR_COLLECT: begin
                if (next_st.aw_held && next_st.w_held) begin
                    next_st.aw_held  = 1'b0;
                    next_st.w_held   = 1'b0;
                    next_st.wr_state = PFSDH_WR_RESP;
                    next_st.resp.bresp = PFSDH_RESP_SLVERR;
                    if (next_st.aw_hi_ok && field_present(next_st.aw_idx)) begin
                        next_st.resp.bresp = PFSDH_RESP_OKAY;
                        if (next_st.w_lane0) begin
                            next_st.sel[next_st.aw_idx[4:0]] = next_st.w_sel;
                        end
                    end
                end
            end
            PFSDH_WR_RESP: begin
                if (axi_req.bready) begin
                    next_st.wr_state = PFSDH_WR_COLLECT;
                end
            end
            default: begin
                next_st.wr_state = PFSDH_WR_COLLECT;
            end
        endcase

        // read channel
        case (st.rd_state)
            PFSDH_RD_IDLE: begin
                if (axi_req.arvalid) begin
                    next_st.rd_state   = PFSDH_RD_DATA;
                    next_st.resp.rdata = 32'h0000_0000;
                    next_st.resp.rresp = PFSDH_RESP_SLVERR;
                    hit = (axi_req.araddr[31:8] == PFSDH_ADDR_HI_ZERO);
                    if (hit && field_present(ridx)) begin
                        next_st.resp.rresp = PFSDH_RESP_OKAY;
                        next_st.resp.rdata[5:0] = st.sel[ridx[4:0]];
                    end else if (hit && ridx == PFSDH_IDX_STATUS) begin
                        next_st.resp.rresp = PFSDH_RESP_OKAY;
                        next_st.resp.rdata[PFSDH_NPIN-1:0] = st.routed;
                    end
                end
            end
            PFSDH_RD_DATA: begin
                if (axi_req.rready) begin
                    next_st.rd_state = PFSDH_RD_IDLE;
                end
            end
            default: begin
                next_st.rd_state = PFSDH_RD_IDLE;
            end
        endcase

        next_st.resp.awready = (next_st.wr_state == PFSDH_WR_COLLECT) && !next_st.aw_held;
        next_st.resp.wready  = (next_st.wr_state == PFSDH_WR_COLLECT) && !next_st.w_held;
        next_st.resp.bvalid  = (next_st.wr_state == PFSDH_WR_RESP);
        next_st.resp.arready = (next_st.rd_state == PFSDH_RD_IDLE);
        next_st.resp.rvalid  = (next_st.rd_state == PFSDH_RD_DATA);

        // pin multiplexer; undecoded or zero code keeps the pin released
        for (int p = 0; p < PFSDH_NPIN; p++) begin
            next_st.routed[p] = code_legal(p, st.sel[p]);
            next_st.drive[p]  = next_st.routed[p] && periph_out[p][st.sel[p]];
            next_st.enable[p] = next_st.routed[p] && periph_oe[p][st.sel[p]];
            next_st.in_q[p]   = next_st.routed[p] && pin_in[p];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.resp.awready <= 1'b1;
            st.resp.wready  <= 1'b1;
            st.resp.arready <= 1'b1;
            for (int p = 0; p < PFSDH_NPIN; p++) begin
                st.sel[p] <= PFSDH_SEL_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    assign axi_resp     = st.resp;
    assign pin_out      = st.drive;
    assign pin_oe       = st.enable;
    assign pin_routed   = st.routed;
    assign pin_sel_code = st.sel;
    assign periph_in    = st.in_q;

endmodule

`default_nettype wire

// ===== design/pfsdh_pkg.sv
// Purpose: constants, types and code tables for the port pin function select block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per select field
// Notes:   bit n of a mask set means select code n is decoded for that pin
`default_nettype none
package pfsdh_pkg;

    localparam int PFSDH_NPIN   = 30;
    localparam int PFSDH_SELW   = 6;
    localparam int PFSDH_NCODE  = 64;

    // variant codes, smallest to largest
    localparam logic [1:0] PFSDH_VAR_SMALL = 2'h0;
    localparam logic [1:0] PFSDH_VAR_MID   = 2'h1;
    localparam logic [1:0] PFSDH_VAR_LARGE = 2'h2;

    // pin index of each select field; byte offset is index * 4
    localparam int PFSDH_IDX_D6 = 0;
    localparam int PFSDH_IDX_D7 = 1;
    localparam int PFSDH_IDX_E3 = 2;
    localparam int PFSDH_IDX_F0 = 7;
    localparam int PFSDH_IDX_G0 = 11;
    localparam int PFSDH_IDX_G7 = 18;
    localparam int PFSDH_IDX_H0 = 19;
    localparam int PFSDH_IDX_J0 = 26;
    localparam logic [5:0] PFSDH_IDX_STATUS = 6'h20;

    localparam logic [5:0]  PFSDH_SEL_RESET = 6'h00;
    localparam logic [5:0]  PFSDH_SEL_HIZ   = 6'h00;
    localparam logic [1:0]  PFSDH_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PFSDH_RESP_SLVERR = 2'h2;
    localparam logic [23:0] PFSDH_ADDR_HI_ZERO = 24'h000000;

    typedef logic [63:0] pfsdh_mask_type;

    // codes decoded on every variant
    localparam pfsdh_mask_type PFSDH_BASE [PFSDH_NPIN] = '{
        64'h0000_0020_0E00_2182, 64'h0000_0020_0E00_2082,   // d6 d7
        64'h0000_0020_6202_10C0, 64'h0000_0020_4002_2046,   // e3 e4
        64'h0000_0020_4006_2006, 64'h0000_0020_6600_2100,   // e5 e6
        64'h0000_0020_6600_2100,                            // e7
        64'h0000_0000_0000_0400, 64'h0000_0000_0000_0000,   // f0 f1
        64'h0000_0000_0000_0400, 64'h0000_0000_0080_0000,   // f2 f5
        64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, // g0..g7
        64'h0000_0000_6000_2400, 64'h0000_0000_6000_2400,   // h0 h1
        64'h0000_0000_4000_2400, 64'h0000_0000_4000_2800,   // h2 h3
        64'h0000_0000_4000_2000, 64'h0000_0000_4000_2000,   // h4 h5
        64'h0000_0400_4000_2000,                            // h6
        64'h0000_0020_0000_2402, 64'h0000_0020_0000_2402,   // j0 j1
        64'h0000_0000_0982_0C02, 64'h0000_0002_0882_0800    // j3 j5
    };

    // codes added on the two larger variants
    localparam pfsdh_mask_type PFSDH_MID [PFSDH_NPIN] = '{
        64'h0000_0000_0030_0000, 64'h0000_0000_0030_0000,
        64'h0, 64'h0, 64'h0, 64'h0, 64'h0,
        64'h0, 64'h0, 64'h0, 64'h0,
        64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFFE,
        64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFFE,
        64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFFE,
        64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFFE,
        64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0,
        64'h0000_0000_0002_0000, 64'h0000_0000_0002_0000,
        64'h0, 64'h0
    };

    // codes added on the largest variant only
    localparam pfsdh_mask_type PFSDH_TOP [PFSDH_NPIN] = '{
        64'h0000_0040_0000_0000, 64'h0000_0040_0000_0000,
        64'h0000_0040_0000_0000, 64'h0000_0040_0000_0000,
        64'h0000_0040_0000_0000, 64'h0, 64'h0,
        64'h0000_0080_0000_0000, 64'h0,
        64'h0000_0080_0000_0000, 64'h0000_0080_0000_0000,
        64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0,
        64'h0000_0080_0000_0000, 64'h0000_0080_0000_0000,
        64'h0000_0080_0000_0000, 64'h0000_0080_0000_0000,
        64'h0000_0080_0000_0000, 64'h0000_0080_0000_0000,
        64'h0000_0080_0000_0000,
        64'h0000_0080_0000_0000, 64'h0000_0080_0000_0000,
        64'h0000_0080_0000_0000, 64'h0000_0080_0000_0000
    };

    typedef enum logic [0:0] {
        PFSDH_WR_COLLECT = 1'b0,
        PFSDH_WR_RESP    = 1'b1
    } pfsdh_wr_state_type;

    typedef enum logic [0:0] {
        PFSDH_RD_IDLE = 1'b0,
        PFSDH_RD_DATA = 1'b1
    } pfsdh_rd_state_type;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } pfsdh_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pfsdh_axi_resp_type;

endpackage

`default_nettype wire

// ===== verif/pfsdh_periph.sv
// Purpose: peripheral side and pad side seen by the pin select block
// Assumes: one drive value and one enable per pin and code
// Notes:   every value flips each cycle, so a stale or wrong code pick shows
`timescale 1ns/1ps
`default_nettype none
module pfsdh_periph
    import pfsdh_pkg::*;
(
    input  wire logic                                   ref_clk,
    output logic      [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0] periph_out,
    output logic      [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0] periph_oe,
    output logic      [PFSDH_NPIN-1:0]                  pin_in
);
    logic ph = 1'b0;

    always @(posedge ref_clk) begin
        ph <= ~ph;
    end
    // neighbouring drive codes differ and enable codes differ in pairs, so a wrong pick shows
    assign periph_out = {(PFSDH_NPIN * PFSDH_NCODE / 4){ph ? 4'hA : 4'h5}};
    assign periph_oe  = {(PFSDH_NPIN * PFSDH_NCODE / 4){ph ? 4'hC : 4'h3}};
    assign pin_in     = {PFSDH_NPIN{~ph}};
endmodule
`default_nettype wire

// ===== verif/pfsdh_chk.sv
// Purpose: pin routing checks at the top module ports
// Assumes: pin results follow select and peripheral inputs by one cycle
// Notes:   bound to every instance together with its variant
`timescale 1ns/1ps
`default_nettype none
module pfsdh_chk
    import pfsdh_pkg::*;
#(
    parameter logic [1:0] variant = PFSDH_VAR_LARGE
) (
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    input  wire logic [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0]  periph_out,
    input  wire logic [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0]  periph_oe,
    input  wire logic [PFSDH_NPIN-1:0]                   pin_out,
    input  wire logic [PFSDH_NPIN-1:0]                   pin_oe,
    input  wire logic [PFSDH_NPIN-1:0]                   pin_routed,
    input  wire logic [PFSDH_NPIN-1:0][PFSDH_SELW-1:0]   pin_sel_code,
    input  wire logic [PFSDH_NPIN-1:0]                   pin_in,
    input  wire logic [PFSDH_NPIN-1:0]                   periph_in
);
    logic [PFSDH_NPIN-1:0] q_out;
    logic [PFSDH_NPIN-1:0] q_in;
    logic [PFSDH_NPIN-1:0] q_oe;
    logic [PFSDH_NPIN-1:0] nz;

    always_comb begin
        for (int p = 0; p < PFSDH_NPIN; p++) begin
            nz[p] = |pin_sel_code[p];
        end
    end
    // peripheral value picked by the current select, one cycle late
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_out <= '0;
            q_oe  <= '0;
            q_in  <= '0;
        end else begin
            q_in  <= pin_in;
            for (int p = 0; p < PFSDH_NPIN; p++) begin
                q_out[p] <= periph_out[p][pin_sel_code[p]];
                q_oe[p]  <= periph_oe[p][pin_sel_code[p]];
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_hiz; (pin_routed & ~$past(nz)) == '0; endproperty
    a_hiz: assert property (p_hiz) else $error("pin routed from zero select");
    property p_out; pin_out == (q_out & pin_routed); endproperty
    a_out: assert property (p_out) else $error("pin value not the selected one");
    property p_oe; pin_oe == (q_oe & pin_routed); endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_in; periph_in == (q_in & pin_routed); endproperty
    a_in: assert property (p_in) else $error("pin level passed to unrouted peripheral");
    property p_d6_eth;
        $past(pin_sel_code[0]) inside {6'h14, 6'h15} |->
            pin_routed[0] == (variant != PFSDH_VAR_SMALL);
    endproperty
    a_d6_eth: assert property (p_d6_eth) else $error("d6 ethernet code wrong");
    property p_d6_top;
        $past(pin_sel_code[0]) == 6'h26 |-> pin_routed[0] == (variant == PFSDH_VAR_LARGE);
    endproperty
    a_d6_top: assert property (p_d6_top) else $error("d6 fieldbus code wrong");
    property p_g_absent;
        variant == PFSDH_VAR_SMALL |-> pin_routed[18:11] == 8'h00 && pin_sel_code[11] == 6'h00;
    endproperty
    a_g_absent: assert property (p_g_absent) else $error("port g live on small variant");
    property p_fb;
        $past(pin_sel_code[19]) == 6'h27 |-> pin_routed[19] == (variant == PFSDH_VAR_LARGE);
    endproperty
    a_fb: assert property (p_fb) else $error("h0 fieldbus code wrong");
    property p_h6_clk; $past(pin_sel_code[25]) == 6'h2A |-> pin_routed[25]; endproperty
    a_h6_clk: assert property (p_h6_clk) else $error("h6 clock output not routed");
endmodule

bind pfsdh_top pfsdh_chk #(.variant(variant)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .periph_out(periph_out), .periph_oe(periph_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_routed(pin_routed), .pin_sel_code(pin_sel_code),
    .pin_in(pin_in), .periph_in(periph_in)
);
`default_nettype wire

// ===== verif/pfsdh_top_test.sv
// Purpose: register driven test of pin function routing on three variants
// Assumes: all three instances share one bus and answer in step
// Notes:   table rows hold pin index, code and routed flags large, small
`timescale 1ns/1ps
`default_nettype none
module pfsdh_top_test
    import pfsdh_pkg::*;
;
    localparam int NT = 32;
    localparam logic [19:0] TV [NT] = '{
        20'h00013, 20'h00083, 20'h00253, 20'h00142, 20'h00152, 20'h00262,
        20'h01013, 20'h01073, 20'h01152, 20'h01262, 20'h02113, 20'h02262,
        20'h04123, 20'h03262, 20'h03113, 20'h05193, 20'h061A3, 20'h0A173,
        20'h07272, 20'h09272, 20'h0B052, 20'h13272, 20'h19272, 20'h192A3,
        20'h1A112, 20'h1B272, 20'h1C183, 20'h1C272, 20'h1D213, 20'h1D113,
        20'h1D272, 20'h00020
    };
    logic                                   ref_clk = 1'b0;
    logic                                   rst_b   = 1'b0;
    pfsdh_axi_req_type                      req     = '0;
    pfsdh_axi_resp_type                     rsp;
    pfsdh_axi_resp_type                     rsp_s;
    logic [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0] p_out;
    logic [PFSDH_NPIN-1:0][PFSDH_NCODE-1:0] p_oe;
    logic [PFSDH_NPIN-1:0]                  p_in;
    logic [PFSDH_NPIN-1:0]                  rt_l;
    logic [PFSDH_NPIN-1:0]                  rt_s;
    logic [PFSDH_NPIN-1:0]                  rt_m;
    logic [5:0]                             ix;
    logic [5:0]                             cd;
    logic [1:0]                             es;
    int                                     err_total = 0;
    int                                     n_checks  = 0;
    int                                     i;

    always #10 ref_clk = ~ref_clk;

    pfsdh_periph u_periph (.ref_clk(ref_clk), .periph_out(p_out), .periph_oe(p_oe), .pin_in(p_in));
    pfsdh_top #(.variant(PFSDH_VAR_LARGE)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .axi_req(req),
        .axi_resp(rsp), .periph_out(p_out), .periph_oe(p_oe), .pin_in(p_in), .pin_out(),
        .pin_oe(), .pin_routed(rt_l), .pin_sel_code(), .periph_in());
    pfsdh_top #(.variant(PFSDH_VAR_SMALL)) DUT_SMALL (.ref_clk(ref_clk), .rst_b(rst_b),
        .axi_req(req), .axi_resp(rsp_s), .periph_out(p_out), .periph_oe(p_oe), .pin_in(p_in),
        .pin_out(), .pin_oe(), .pin_routed(rt_s), .pin_sel_code(), .periph_in());
    pfsdh_top #(.variant(PFSDH_VAR_MID)) DUT_MID (.ref_clk(ref_clk), .rst_b(rst_b),
        .axi_req(req), .axi_resp(), .periph_out(p_out), .periph_oe(p_oe), .pin_in(p_in),
        .pin_out(), .pin_oe(), .pin_routed(rt_m), .pin_sel_code(), .periph_in());

    task chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] el, input logic [1:0] e2);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{awaddr:a, awvalid:1'b1, wdata:d, wstrb:4'hF, wvalid:1'b1, bready:1'b1,
                 default:'0};
        do begin
            @(posedge ref_clk);
            n++;
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 50);
        req.bready <= 1'b0;
        chk(rsp.bvalid === 1'b1 && rsp.bresp === el, "write response");
        chk(rsp_s.bvalid === 1'b1 && rsp_s.bresp === e2, "small write response");
    endtask

    task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er,
            input logic [31:0] ed2, input logic [1:0] er2);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{araddr:a, arvalid:1'b1, rready:1'b1, default:'0};
        do begin
            @(posedge ref_clk);
            n++;
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 50);
        req.rready <= 1'b0;
        chk(rsp.rvalid === 1'b1 && rsp.rdata === ed && rsp.rresp === er, "read data");
        chk(rsp_s.rvalid === 1'b1 && rsp_s.rdata === ed2 && rsp_s.rresp === er2,
            "small read data");
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (i = 0; i < PFSDH_NPIN; i++) begin
            es = (i >= 11 && i <= 18) ? PFSDH_RESP_SLVERR : PFSDH_RESP_OKAY;
            rd(32'(i) * 4, 32'h0, PFSDH_RESP_OKAY, 32'h0, es);
        end
        $display("test reset values done");
        for (i = 0; i < NT; i++) begin
            ix = TV[i][17:12];
            cd = TV[i][9:4];
            es = (ix >= 11 && ix <= 18) ? PFSDH_RESP_SLVERR : PFSDH_RESP_OKAY;
            wr({24'h0, ix, 2'h0}, {26'h3FFFFFF, cd}, PFSDH_RESP_OKAY, es);
            rd({24'h0, ix, 2'h0}, {26'h0, cd}, PFSDH_RESP_OKAY,
               (es == PFSDH_RESP_OKAY) ? {26'h0, cd} : 32'h0, es);
            repeat (2) @(posedge ref_clk);
            chk(rt_l[ix] === TV[i][1], "routed on large variant");
            chk(rt_s[ix] === TV[i][0], "routed on small variant");
            chk(rt_m[ix] === ((cd inside {6'h26, 6'h27}) ? TV[i][0] : TV[i][1]),
                "routed on middle variant");
            rd(32'h80, 32'(TV[i][1]) << ix, PFSDH_RESP_OKAY,
               32'(TV[i][0]) << ix, PFSDH_RESP_OKAY);
            wr({24'h0, ix, 2'h0}, 32'h0, PFSDH_RESP_OKAY, es);
            repeat (2) @(posedge ref_clk);
            chk(rt_l[ix] === 1'b0 && rt_s[ix] === 1'b0 && rt_m[ix] === 1'b0,
                "pin still routed");
        end
        $display("test code table done");
        wr(32'h78, 32'h1, PFSDH_RESP_SLVERR, PFSDH_RESP_SLVERR);
        wr(32'h80, 32'h1, PFSDH_RESP_SLVERR, PFSDH_RESP_SLVERR);
        wr(32'h100, 32'h1, PFSDH_RESP_SLVERR, PFSDH_RESP_SLVERR);
        rd(32'h100, 32'h0, PFSDH_RESP_SLVERR, 32'h0, PFSDH_RESP_SLVERR);
        $display("test unmapped done");
        close_out;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        close_out;
    end
endmodule
`default_nettype wire
